// *** verilog/stage_input_map.svh ***
// Register offsets, field positions, reset values and timing counts of the stage input block
`ifndef STAGE_INPUT_MAP_SVH
`define STAGE_INPUT_MAP_SVH
`define MAP_ADDR_W        3
`define MAP_OFS_CTRL      3'h0
`define MAP_OFS_CFG_A     3'h1
`define MAP_OFS_CFG_B     3'h2
`define MAP_OFS_CAP_LOW   3'h3
`define MAP_OFS_CAP_HIGH  3'h4
`define MAP_OFS_FLAGS     3'h5
`define MAP_OFS_STATUS    3'h6
`define MAP_CTRL_RUN      0
`define MAP_CTRL_FINISH   1
`define MAP_CTRL_FOLLOW   2
`define MAP_CAP_SW_BIT    7
`define MAP_CFG_RESET     8'h00
`define MAP_CTRL_RESET    3'h0
`define MAP_CAP_RESET     12'h000
`define MAP_FILTER_SAMPLES 4
`endif

// *** verilog/stage_input_pkg.sv ***
// Types shared by the stage input block
package stage_input_pkg;
  typedef enum logic [3:0] {
    MODE_IGNORE     = 4'h0,
    MODE_JUMP_WAIT  = 4'h1,
    MODE_EXEC_WAIT  = 4'h2,
    MODE_OPPOSITE   = 4'h3,
    MODE_DEACTIVATE = 4'h4,
    MODE_INSERT_DT  = 4'h5,
    MODE_JUMP_WAIT6 = 4'h6,
    MODE_HALT       = 4'h7,
    MODE_RETRIG     = 4'h8,
    MODE_FIXED      = 4'h9,
    MODE_FIXED_OFF  = 4'hE
  } fault_mode_t;

  typedef struct packed {
    logic        capture_enable;
    logic        input_source_select;
    logic        event_polarity_select;
    logic        noise_filter_enable;
    logic [3:0]  fault_retrigger_mode;
  } input_cfg_t;

  typedef struct packed {
    logic stop_signal;
    logic jump_dead_time;
    logic exec_dead_time;
    logic run_opposite;
    logic insert_dead_time;
    logic deactivate;
    logic halt;
    logic retrigger;
    logic fixed_frequency;
  } fault_action_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_RUN    = 3'b010,
    ST_FINISH = 3'b100
  } run_state_t;
endpackage

// *** verilog/power_stage_input_capture_fault.sv ***
// Input capture, retrigger/fault blocks and run control of the third stage controller
`timescale 1ns/1ps
`include "stage_input_map.svh"

module power_stage_input_capture_fault
  import stage_input_pkg::*;
(
  input  wire logic                   i_clock,
  input  wire logic                   i_nrst,
  input  wire logic [`MAP_ADDR_W-1:0] i_addr,
  input  wire logic [7:0]             i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  output logic      [7:0]             o_rdata,
  input  wire logic                   i_external_fault_pin,
  input  wire logic                   i_comparator_out,
  input  wire logic [11:0]            i_counter,
  input  wire logic                   i_cycle_end,
  input  wire logic                   i_first_run_request,
  input  wire logic                   i_second_run_request,
  input  wire logic                   i_second_follow_previous,
  output logic                        o_running,
  output fault_action_t               o_action_a,
  output fault_action_t               o_action_b
);

  // Register file
  logic                 run_request;
  logic                 finish_cycle_on_stop;
  logic                 follow_previous_start;
  input_cfg_t           cfg [2];
  logic [11:0]          capture_value;
  logic                 capture_from_software;
  logic [7:0]           temp_high;
  logic [1:0]           event_flag;
  logic                 halted;
  run_state_t           state;
  run_state_t           next_state;
  fault_action_t        action [2];
  fault_action_t        next_action [2];

  // Per-block event path
  logic [1:0]           block_level;
  logic [1:0]           block_event;
  logic [1:0]           block_capture;
  logic [1:0]           block_flag_set;
  logic [1:0]           block_halt;

  // Bus decode
  wire wr_ctrl   = i_wr && (i_addr == `MAP_OFS_CTRL);
  wire wr_cfg_a  = i_wr && (i_addr == `MAP_OFS_CFG_A);
  wire wr_cfg_b  = i_wr && (i_addr == `MAP_OFS_CFG_B);
  wire wr_high   = i_wr && (i_addr == `MAP_OFS_CAP_HIGH);
  wire wr_flags  = i_wr && (i_addr == `MAP_OFS_FLAGS);
  wire rd_low    = i_rd && (i_addr == `MAP_OFS_CAP_LOW);
  wire sw_capture = wr_high && i_wdata[`MAP_CAP_SW_BIT];
  wire hw_capture = |block_capture;
  wire [7:0] high_byte = {capture_from_software, 3'h0, capture_value[11:8]};

  // Run control
  wire autorun_go = follow_previous_start &&
                    (i_second_run_request || (i_second_follow_previous && i_first_run_request));
  wire halt_event = |block_halt;
  wire halt_now   = halt_event || halted;
  wire run_go     = (run_request || autorun_go) && !halt_now;
  wire finish_ok  = finish_cycle_on_stop && !follow_previous_start;
  wire next_halted = halt_event || (halted && !wr_ctrl);

  // Registers
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      {follow_previous_start, finish_cycle_on_stop, run_request} <= `MAP_CTRL_RESET;
    end else if (wr_ctrl) begin
      run_request           <= i_wdata[`MAP_CTRL_RUN];
      finish_cycle_on_stop  <= i_wdata[`MAP_CTRL_FINISH];
      follow_previous_start <= i_wdata[`MAP_CTRL_FOLLOW];
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      cfg[0] <= `MAP_CFG_RESET;
      cfg[1] <= `MAP_CFG_RESET;
    end else begin
      if (wr_cfg_a) cfg[0] <= i_wdata;
      if (wr_cfg_b) cfg[1] <= i_wdata;
    end
  end

  // Software trigger beats a simultaneous input capture
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      capture_value         <= `MAP_CAP_RESET;
      capture_from_software <= 1'b0;
    end else if (sw_capture || hw_capture) begin
      capture_value         <= i_counter;
      capture_from_software <= sw_capture;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      temp_high <= 8'h00;
    end else if (rd_low) begin
      temp_high <= high_byte;
    end
  end

  // Write one clears; a new event in the same cycle keeps the flag
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      event_flag <= 2'h0;
    end else begin
      event_flag <= block_flag_set | (event_flag & ~(wr_flags ? i_wdata[1:0] : 2'h0));
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      halted <= 1'b0;
      state  <= ST_IDLE;
    end else begin
      halted <= next_halted;
      state  <= next_state;
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (run_go) next_state = ST_RUN;
      end
      ST_RUN: begin
        if (halt_now) next_state = ST_IDLE;
        else if (!run_go) next_state = finish_ok ? ST_FINISH : ST_IDLE;
      end
      ST_FINISH: begin
        if (halt_now || i_cycle_end) next_state = ST_IDLE;
        else if (run_go) next_state = ST_RUN;
      end
    endcase
  end

  assign o_running = (state != ST_IDLE);

  // Read port: data stand one cycle after the strobe
  logic [7:0] read_mux;
  always_comb begin
    read_mux = 8'h00;
    unique case (i_addr)
      `MAP_OFS_CTRL:     read_mux = {5'h00, follow_previous_start, finish_cycle_on_stop, run_request};
      `MAP_OFS_CFG_A:    read_mux = cfg[0];
      `MAP_OFS_CFG_B:    read_mux = cfg[1];
      `MAP_OFS_CAP_LOW:  read_mux = capture_value[7:0];
      `MAP_OFS_CAP_HIGH: read_mux = temp_high;
      `MAP_OFS_FLAGS:    read_mux = {6'h00, event_flag};
      `MAP_OFS_STATUS:   read_mux = {5'h00, state == ST_FINISH, halted, o_running};
      default:           read_mux = 8'h00;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= i_rd ? read_mux : 8'h00;
    end
  end

  // Two identical input blocks
  for (genvar g = 0; g < 2; g++) begin : g_block
    logic [`MAP_FILTER_SAMPLES-1:0] samples;
    logic                           filtered;
    logic                           prev_level;
    wire selected = cfg[g].input_source_select ? i_comparator_out : i_external_fault_pin;
    wire active   = cfg[g].event_polarity_select ? selected : ~selected;
    wire all_one  = &samples;
    wire all_zero = ~|samples;
    wire [3:0] mode = cfg[g].fault_retrigger_mode;
    wire mode_on  = (mode != MODE_IGNORE);

    always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
        samples    <= '0;
        filtered   <= 1'b0;
        prev_level <= 1'b0;
      end else begin
        samples    <= {samples[`MAP_FILTER_SAMPLES-2:0], active};
        filtered   <= all_one ? 1'b1 : (all_zero ? 1'b0 : filtered);
        prev_level <= block_level[g];
      end
    end

    assign block_level[g]    = cfg[g].noise_filter_enable ? filtered : active;
    assign block_event[g]    = block_level[g] && !prev_level;
    assign block_capture[g]  = block_event[g] && cfg[g].capture_enable;
    assign block_flag_set[g] = block_event[g] && (mode_on || cfg[g].capture_enable);
    assign block_halt[g]     = block_event[g] && (mode == MODE_HALT);

    // Fault modes act while the level persists, halt from the event until a control write; retrigger modes pulse on the edge
    always_comb begin
      next_action[g] = '0;
      unique case (mode)
        MODE_JUMP_WAIT, MODE_JUMP_WAIT6: begin
          next_action[g].stop_signal    = block_level[g];
          next_action[g].jump_dead_time = block_level[g];
        end
        MODE_EXEC_WAIT: begin
          next_action[g].stop_signal    = block_level[g];
          next_action[g].exec_dead_time = block_level[g];
        end
        MODE_OPPOSITE: begin
          next_action[g].stop_signal  = block_level[g];
          next_action[g].run_opposite = block_level[g];
        end
        MODE_DEACTIVATE: next_action[g].deactivate = block_level[g];
        MODE_INSERT_DT: begin
          next_action[g].stop_signal      = block_level[g];
          next_action[g].insert_dead_time = block_level[g];
        end
        MODE_HALT: next_action[g].halt = halted || block_halt[g];
        MODE_RETRIG: next_action[g].retrigger = block_event[g];
        MODE_FIXED: begin
          next_action[g].retrigger       = block_event[g];
          next_action[g].fixed_frequency = 1'b1;
        end
        MODE_FIXED_OFF: begin
          next_action[g].retrigger       = block_event[g];
          next_action[g].fixed_frequency = 1'b1;
          next_action[g].deactivate      = block_level[g];
        end
        default: next_action[g] = '0;
      endcase
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) action[g] <= '0;
      else action[g] <= next_action[g];
    end
  end

  assign o_action_a = action[0];
  assign o_action_b = action[1];

  // Checks
  wire filtered_a = g_block[0].filtered;
  wire active_a   = g_block[0].active;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  a_run_write_start: assert property (wr_ctrl && i_wdata[`MAP_CTRL_RUN] && !halt_event |=> ##1 o_running)
    else $error("run request write did not start the controller");
  a_run_prevails: assert property (run_request && !wr_ctrl && !halt_now && state == ST_RUN |=> state == ST_RUN)
    else $error("run request did not keep the controller running");
  a_follow_start: assert property (follow_previous_start && i_second_run_request && !halt_now && state == ST_IDLE
                                   |=> state == ST_RUN)
    else $error("follow-previous start missed");
  a_finish_cycle: assert property (state == ST_RUN && !run_go && !halt_now && finish_ok
                                   |=> state == ST_FINISH ##0 o_running)
    else $error("stop did not wait for cycle end");
  a_follow_no_finish: assert property (state == ST_RUN && !run_go && follow_previous_start |=> state == ST_IDLE)
    else $error("finish cycle honoured while following");
  a_mode_ignore: assert property (cfg[0].fault_retrigger_mode == MODE_IGNORE && !wr_cfg_a |=> o_action_a == '0)
    else $error("ignored input produced an action");
  a_capture_load: assert property (block_capture[0] && !sw_capture |=> capture_value == $past(i_counter)
                                   && !capture_from_software)
    else $error("input capture did not load the counter");
  a_sw_capture: assert property (sw_capture |=> capture_from_software && capture_value == $past(i_counter))
    else $error("software capture not reported");
  a_sw_latch: assert property (rd_low && capture_from_software |=> temp_high[7])
    else $error("software origin lost in the temporary latch");
  a_event_flag: assert property (block_flag_set[1] |=> event_flag[1])
    else $error("event flag not set");
  a_temp_latch: assert property (rd_low |=> temp_high == $past(high_byte) && temp_high[6:4] == 3'h0)
    else $error("temporary latch not loaded on low read");
  a_filter_wait: assert property (cfg[0].noise_filter_enable && $rose(filtered_a) |-> $past(active_a, 4))
    else $error("filter changed without four equal samples");

  a_filter_fall: assert property ($fell(filtered_a) |-> !$past(active_a, 4))
    else $error("filter dropped without four equal samples");
  a_sw_wins: assert property (sw_capture && hw_capture |=> capture_from_software)
    else $error("input capture overrode the software trigger");
  a_latch_high: assert property (rd_low |=> temp_high[3:0] == $past(capture_value[11:8]))
    else $error("temporary latch lost counter bits 11 to 8");
  a_low_read: assert property (rd_low |=> o_rdata == $past(capture_value[7:0]))
    else $error("capture low byte read wrong");
  a_high_read: assert property (i_rd && i_addr == `MAP_OFS_CAP_HIGH |=> o_rdata == $past(temp_high))
    else $error("capture high byte not served from the latch");
  a_no_capture: assert property (!cfg[0].capture_enable && !cfg[1].capture_enable && !sw_capture
                                 |=> $stable(capture_value))
    else $error("capture loaded with both blocks disabled");
  a_flag_clear: assert property (wr_flags && i_wdata[0] && !block_flag_set[0] |=> !event_flag[0])
    else $error("event flag not cleared by write one");
  a_flag_hold: assert property (event_flag[1] && !wr_flags |=> event_flag[1])
    else $error("event flag lost without a clear");
  a_cfg_write: assert property (wr_cfg_b |=> cfg[1] == $past(i_wdata))
    else $error("block B configuration not written");
  a_ignore_b: assert property (cfg[1].fault_retrigger_mode == MODE_IGNORE |=> o_action_b == '0)
    else $error("ignored block B input produced an action");
  a_rise_source: assert property (cfg[0].event_polarity_select && !cfg[0].noise_filter_enable &&
                                  block_event[0] |->
                                  (cfg[0].input_source_select ? i_comparator_out : i_external_fault_pin))
    else $error("rising event without a high selected input");
  a_fall_source: assert property (!cfg[1].event_polarity_select && !cfg[1].noise_filter_enable &&
                                  block_event[1] |->
                                  !(cfg[1].input_source_select ? i_comparator_out : i_external_fault_pin))
    else $error("falling event without a low selected input");
  a_halt_stops: assert property (halt_event |=> halted && !o_running)
    else $error("halt event did not stop the controller");
  a_halt_blocks: assert property (halted && !wr_ctrl |=> !o_running)
    else $error("controller ran while halted");
  a_halt_action: assert property (cfg[0].fault_retrigger_mode == MODE_HALT && halted |=> o_action_a.halt)
    else $error("halt action missing while halted");
  a_jump_dt: assert property (cfg[0].fault_retrigger_mode == MODE_JUMP_WAIT6 && block_level[0]
                              |=> o_action_a.stop_signal && o_action_a.jump_dead_time)
    else $error("jump to opposite dead-time missing");
  a_exec_dt: assert property (cfg[0].fault_retrigger_mode == MODE_EXEC_WAIT && block_level[0]
                              |=> o_action_a.stop_signal && o_action_a.exec_dead_time)
    else $error("opposite dead-time execution missing");
  a_opposite: assert property (cfg[0].fault_retrigger_mode == MODE_OPPOSITE && block_level[0]
                               |=> o_action_a.stop_signal && o_action_a.run_opposite)
    else $error("opposite phase not run during fault");
  a_insert_dt: assert property (cfg[0].fault_retrigger_mode == MODE_INSERT_DT && block_level[0]
                                |=> o_action_a.stop_signal && o_action_a.insert_dead_time)
    else $error("dead-time insertion missing");
  a_deact_only: assert property (cfg[0].fault_retrigger_mode == MODE_DEACTIVATE && block_level[0]
                                 |=> o_action_a.deactivate && !o_action_a.stop_signal)
    else $error("deactivation changed the timing");
  a_retrig_pulse: assert property (cfg[0].fault_retrigger_mode == MODE_RETRIG && block_event[0]
                                   |=> o_action_a.retrigger)
    else $error("edge retrigger missing");
  a_retrig_once: assert property (o_action_a.retrigger |=> !o_action_a.retrigger)
    else $error("retrigger longer than one cycle");
  a_fixed_level: assert property (cfg[1].fault_retrigger_mode == MODE_FIXED
                                  |=> o_action_b.fixed_frequency)
    else $error("fixed frequency level missing");
  a_finish_hold: assert property (state == ST_FINISH && !halt_now && !i_cycle_end && !run_go
                                  |=> state == ST_FINISH)
    else $error("controller stopped before the cycle end");
  a_finish_end: assert property (state == ST_FINISH && i_cycle_end |=> state == ST_IDLE)
    else $error("controller kept running after the cycle end");
  a_idle_stays: assert property (state == ST_IDLE && !run_request && !follow_previous_start |=> !o_running)
    else $error("controller started without a start condition");
  a_ctrl_write: assert property (wr_ctrl |=> run_request == $past(i_wdata[`MAP_CTRL_RUN]))
    else $error("run request not written");
  a_autorun_second: assert property (follow_previous_start && i_second_follow_previous &&
                                     i_first_run_request && !halt_now && state == ST_IDLE
                                     |=> state == ST_RUN)
    else $error("follow-previous start through the first controller missed");

  c_finish_end: cover property (state == ST_FINISH ##1 state == ST_IDLE);
  c_capture_b:  cover property (block_capture[1]);
  c_halt:       cover property (halt_event ##[1:20] wr_ctrl);
  c_coherent:   cover property (rd_low ##1 (i_rd && i_addr == `MAP_OFS_CAP_HIGH));
  c_sw_read:    cover property (sw_capture ##[1:10] rd_low);

endmodule // power_stage_input_capture_fault

// *** test/fault_source_model.sv ***
// Model of the external fault pin and comparator output feeding the input blocks
`timescale 1ns/1ps

module fault_source_model (
  input  wire logic i_clock,
  input  wire logic i_nrst,
  input  wire logic i_pin_level,
  input  wire logic i_cmp_level,
  output logic      o_pin,
  output logic      o_cmp
);
  // Both sources are synchronous to the stage clock and change just after an edge
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pin <= 1'b0;
      o_cmp <= 1'b0;
    end else begin
      o_pin <= i_pin_level;
      o_cmp <= i_cmp_level;
    end
  end
endmodule // fault_source_model

// *** test/power_stage_input_capture_fault_tb.sv ***
// Register-level testbench of the stage input capture and fault block
`timescale 1ns/1ps
`include "stage_input_map.svh"

module power_stage_input_capture_fault_tb
  import stage_input_pkg::*;
();
  logic          i_clock, i_nrst, i_wr, i_rd, i_cycle_end;
  logic [2:0]    i_addr;
  logic [7:0]    i_wdata, o_rdata, rdat;
  logic [11:0]   i_counter;
  logic          first_run, second_run, second_follow, o_running;
  logic          pin_level, cmp_level, ext_pin, cmp_out;
  fault_action_t o_action_a, o_action_b;
  logic [8:0]    acc;
  int            err_total, num_checks;
  logic [3:0]    mode_tab [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hE};
  logic [8:0]    mask_tab [11] = '{9'h000, 9'h180, 9'h140, 9'h120, 9'h008, 9'h110, 9'h180, 9'h004,
                                   9'h002, 9'h003, 9'h00B};

  power_stage_input_capture_fault u_power_stage_input_capture_fault (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_external_fault_pin(ext_pin), .i_comparator_out(cmp_out),
    .i_counter(i_counter), .i_cycle_end(i_cycle_end), .i_first_run_request(first_run),
    .i_second_run_request(second_run), .i_second_follow_previous(second_follow),
    .o_running(o_running), .o_action_a(o_action_a), .o_action_b(o_action_b));

  fault_source_model u_fault_source_model (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_pin_level(pin_level), .i_cmp_level(cmp_level),
    .o_pin(ext_pin), .o_cmp(cmp_out));

  always #12.5 i_clock = ~i_clock;

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_addr <= a; i_wdata <= d; i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
    @(posedge i_clock);
    i_addr <= a; i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 rdat = o_rdata;
    chk({1'b0, rdat}, {1'b0, exp});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask

  task automatic src(input logic p, input logic c, input logic [11:0] cnt);
    @(posedge i_clock);
    pin_level <= p; cmp_level <= c; i_counter <= cnt;
  endtask

  task automatic ext(input logic f, input logic s, input logic sf);
    @(posedge i_clock);
    first_run <= f; second_run <= s; second_follow <= sf;
  endtask

  task automatic mode_test(input logic blk, input logic [3:0] m, input logic [8:0] mask);
    wr(blk ? `MAP_OFS_CFG_B : `MAP_OFS_CFG_A, {4'h2, m});
    src(1'b1, 1'b0, 12'h000);
    acc = 9'h000;
    repeat (6) begin
      @(posedge i_clock);
      #1 acc = acc | (blk ? o_action_b : o_action_a);
    end
    chk(acc, mask);
    if (m == 4'h7) begin
      chk({8'h00, o_running}, 9'h000);
      rchk(`MAP_OFS_STATUS, 8'h02);
    end
    src(1'b0, 1'b0, 12'h000);
    wr(blk ? `MAP_OFS_CFG_B : `MAP_OFS_CFG_A, 8'h00);
    wr(`MAP_OFS_CTRL, 8'h01);
    cyc(2);
  endtask

  task automatic done(input string name);
    $display("Test %s finished, mismatches so far %0d", name, err_total);
  endtask

  task automatic results();
    $display("Checks %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #(25 * 6000);
    err_total++;
    $display("[FAIL] t=%0t watchdog expired", $time);
    results();
  end

  initial begin
    i_clock = 1'b0; i_nrst = 1'b0; i_wr = 1'b0; i_rd = 1'b0; i_addr = 3'h0; i_wdata = 8'h00;
    i_cycle_end = 1'b0; i_counter = 12'h000; first_run = 1'b0; second_run = 1'b0;
    second_follow = 1'b0; pin_level = 1'b0; cmp_level = 1'b0; err_total = 0; num_checks = 0;
    repeat (10) @(posedge i_clock);
    i_nrst <= 1'b1;
    for (int a = 0; a < 8; a++) rchk(3'(a), 8'h00);
    wr(`MAP_OFS_CFG_A, 8'hA5);
    rchk(`MAP_OFS_CFG_A, 8'hA5);
    wr(`MAP_OFS_CFG_B, 8'h39);
    rchk(`MAP_OFS_CFG_B, 8'h39);
    wr(`MAP_OFS_CFG_A, 8'h00);
    wr(`MAP_OFS_CFG_B, 8'h00);
    done("reset and config");
    wr(`MAP_OFS_CTRL, 8'h01);
    cyc(2);
    chk({8'h00, o_running}, 9'h001);
    for (int i = 0; i < 11; i++) mode_test(1'b0, mode_tab[i], mask_tab[i]);
    mode_test(1'b1, 4'h1, 9'h180);
    done("modes");
    wr(`MAP_OFS_FLAGS, 8'h03);
    wr(`MAP_OFS_CFG_A, 8'hA0);
    src(1'b1, 1'b0, 12'hABC);
    cyc(4);
    src(1'b0, 1'b0, 12'h5D1);
    cyc(2);
    rchk(`MAP_OFS_CAP_LOW, 8'hBC);
    rchk(`MAP_OFS_FLAGS, 8'h01);
    src(1'b1, 1'b0, 12'h5D1);
    cyc(4);
    rchk(`MAP_OFS_CAP_HIGH, 8'h0A);
    rchk(`MAP_OFS_CAP_LOW, 8'hD1);
    rchk(`MAP_OFS_CAP_HIGH, 8'h05);
    src(1'b0, 1'b0, 12'h3E7);
    wr(`MAP_OFS_CAP_HIGH, 8'h80);
    cyc(2);
    rchk(`MAP_OFS_CAP_LOW, 8'hE7);
    rchk(`MAP_OFS_CAP_HIGH, 8'h83);
    done("capture");
    wr(`MAP_OFS_CFG_A, 8'h00);
    wr(`MAP_OFS_CFG_B, 8'hC0);
    src(1'b0, 1'b1, 12'h777);
    cyc(3);
    wr(`MAP_OFS_FLAGS, 8'h03);
    src(1'b1, 1'b1, 12'h777);
    cyc(3);
    src(1'b1, 1'b0, 12'h0F0);
    cyc(4);
    rchk(`MAP_OFS_CAP_LOW, 8'hF0);
    rchk(`MAP_OFS_CAP_HIGH, 8'h00);
    rchk(`MAP_OFS_FLAGS, 8'h02);
    wr(`MAP_OFS_CFG_B, 8'h00);
    wr(`MAP_OFS_CFG_A, 8'hB0);
    src(1'b0, 1'b0, 12'h111);
    cyc(3);
    wr(`MAP_OFS_FLAGS, 8'h03);
    src(1'b1, 1'b0, 12'h111);
    src(1'b1, 1'b0, 12'h111);
    src(1'b0, 1'b0, 12'h111);
    cyc(8);
    rchk(`MAP_OFS_FLAGS, 8'h00);
    src(1'b1, 1'b0, 12'h222);
    cyc(2);
    rchk(`MAP_OFS_FLAGS, 8'h00);
    cyc(6);
    rchk(`MAP_OFS_CAP_LOW, 8'h22);
    rchk(`MAP_OFS_FLAGS, 8'h01);
    done("sources and filter");
    wr(`MAP_OFS_CTRL, 8'h03);
    wr(`MAP_OFS_CTRL, 8'h02);
    cyc(3);
    chk({8'h00, o_running}, 9'h001);
    rchk(`MAP_OFS_STATUS, 8'h05);
    @(posedge i_clock);
    i_cycle_end <= 1'b1;
    @(posedge i_clock);
    i_cycle_end <= 1'b0;
    cyc(3);
    chk({8'h00, o_running}, 9'h000);
    wr(`MAP_OFS_CTRL, 8'h06);
    rchk(`MAP_OFS_CTRL, 8'h06);
    ext(1'b0, 1'b1, 1'b0);
    cyc(3);
    chk({8'h00, o_running}, 9'h001);
    ext(1'b1, 1'b0, 1'b1);
    cyc(3);
    chk({8'h00, o_running}, 9'h001);
    ext(1'b0, 1'b0, 1'b1);
    cyc(3);
    chk({8'h00, o_running}, 9'h000);
    ext(1'b0, 1'b0, 1'b0);
    wr(`MAP_OFS_CTRL, 8'h05);
    cyc(2);
    chk({8'h00, o_running}, 9'h001);
    wr(`MAP_OFS_CTRL, 8'h04);
    cyc(3);
    chk({8'h00, o_running}, 9'h000);
    done("run control");
    results();
  end
endmodule // power_stage_input_capture_fault_tb
